// ---- shared/pmic_protect_map.svh ----
`ifndef PMIC_PROTECT_MAP_SVH
`define PMIC_PROTECT_MAP_SVH

// Clock and timing
`define CLK_PERIOD_NS 25
`define DEGLITCH_NS 2000
`define DEGLITCH_CYC ((`DEGLITCH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RAMP_STEP_NS 1000
`define RAMP_STEP_CYC ((`RAMP_STEP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SYNC_ONLY_CYC 1

// Counter widths and limits
`define DG_CNT_W 16
`define STEP_W 16
`define SS_W 8
`define SS_MAX 8'hff
`define SS_ZERO 8'h00

// Comparator vector layout
`define CMP_N 13
`define CMP_BUCK_OV_LO 0
`define CMP_BUCK_OV_HI 2
`define CMP_BUCK_UV_LO 3
`define CMP_BUCK_UV_HI 5
`define CMP_LDO_UV 6
`define CMP_VIN_OV 9

// Serial target
`define BYTE_W 8
`define BITS_PER_BYTE 4'h8
`define BITCNT_W 4
`define I2C_ADDR 7'h1b
`define REG_CTRL 8'h00
`define REG_STAT 8'h01
`define REG_NONE 8'h00
`define CTRL_RESET 8'h01
`define CTRL_EXT1_BIT 0
`define STAT_RESET 8'h00

// Status word bit positions
`define STAT_OV_LO 0
`define STAT_OV_HI 2
`define STAT_UV_LATCH 3
`define STAT_OT 4
`define STAT_VIN_OV 5
`define STAT_POWER_GOOD_OUT 6
`define STAT_RAILS 7

`endif

// ---- shared/pmic_protect_pkg.sv ----
`include "pmic_protect_map.svh"
package pmic_protect_pkg;

  // Power sequencing states
  typedef enum logic [2:0] {S_OFF, S_RAMP, S_ON, S_OT, S_VOV, S_LATCH} seq_state_t;

  // Serial target states
  typedef enum logic [3:0] {
    T_IDLE, T_ADDR, T_ACK_A, T_REG, T_ACK_R, T_WDATA, T_ACK_W, T_RDATA, T_RACK
  } i2c_state_t;

  // Comparator and strap inputs, high field first
  typedef struct packed {
    logic thresh_5v;
    logic por_ok;
    logic uvlo;
    logic vin_ov;
    logic ot_cool;
    logic ot_hot;
    logic ldo_uv;
    logic [2:0] buck_uv;
    logic [2:0] buck_ov;
  } cmp_t;

  // Registered outputs
  typedef struct packed {
    logic [2:0] buck_en;
    logic [2:0] drv_en;
    logic [2:0] ov_flag;
    logic ldo_en;
    logic ldo_dis;
    logic ext1;
    logic sense_dis;
    logic gate;
    logic power_good_out;
    logic thresh_5v;
  } rail_out_t;

  // Serial target registers
  typedef struct packed {
    i2c_state_t state;
    logic [`BITCNT_W-1:0] bitcnt;
    logic [`BYTE_W-1:0] shreg;
    logic [`BYTE_W-1:0] txsh;
    logic [`BYTE_W-1:0] ptr;
    logic [`BYTE_W-1:0] ctrl;
    logic oe;
    logic rw;
    logic mack;
  } i2c_regs_t;

endpackage

// ---- hw/deglitch_filter.sv ----
`timescale 1ns/10ps
`include "pmic_protect_map.svh"
module deglitch_filter #(
  parameter int unsigned LEN = `DEGLITCH_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic raw,
  output logic q
);

  logic s1_ff;
  logic s2_ff;
  logic [`DG_CNT_W-1:0] cnt_ff;
  logic [`DG_CNT_W-1:0] nxt_cnt;
  logic nxt_q;
  wire logic [`DG_CNT_W-1:0] len_c = `DG_CNT_W'(LEN);

  // Two-stage synchroniser
  always_ff @(posedge clk) begin
    s1_ff <= rst ? 1'h0 : raw;
    s2_ff <= rst ? 1'h0 : s1_ff;
  end

  // Any drop restarts the count; qualify at terminal count
  assign nxt_cnt = !s2_ff ? '0 : (cnt_ff == len_c) ? cnt_ff : cnt_ff + `DG_CNT_W'(1);
  assign nxt_q = s2_ff && (nxt_cnt == len_c);

  always_ff @(posedge clk) begin
    cnt_ff <= rst ? '0 : nxt_cnt;
    q <= rst ? 1'h0 : nxt_q;
  end

  a_drop_clears: assert property (@(posedge clk) disable iff (rst)
    !s2_ff |=> !q) else $error("deglitch output survived an input drop");
  a_full_length: assert property (@(posedge clk) disable iff (rst)
    q |-> cnt_ff == len_c && $past(s2_ff)) else $error("deglitch qualified too early");

endmodule

// ---- hw/cdc_word_handshake.sv ----
`timescale 1ns/10ps
`include "pmic_protect_map.svh"
module cdc_word_handshake #(
  parameter logic [`BYTE_W-1:0] RESET_VAL = `STAT_RESET
) (
  input wire logic src_clk,
  input wire logic src_rst,
  input wire logic [`BYTE_W-1:0] src_data,
  input wire logic dst_clk,
  input wire logic dst_rst,
  output logic [`BYTE_W-1:0] dst_data
);

  logic req_ff;
  logic [`BYTE_W-1:0] hold_ff;
  logic ack_s1_ff;
  logic ack_s2_ff;
  logic req_s1_ff;
  logic req_s2_ff;
  logic req_s3_ff;
  logic ack_ff;
  wire logic src_idle = (ack_s2_ff == req_ff);
  wire logic dst_new = (req_s2_ff != req_s3_ff);

  // Source side: hold word stable while a request is in flight
  always_ff @(posedge src_clk) begin
    req_ff <= src_rst ? 1'h0 : (src_idle ? ~req_ff : req_ff);
    hold_ff <= src_rst ? RESET_VAL : (src_idle ? src_data : hold_ff);
    ack_s1_ff <= src_rst ? 1'h0 : ack_ff;
    ack_s2_ff <= src_rst ? 1'h0 : ack_s1_ff;
  end

  // Destination side: capture on request toggle and return it
  always_ff @(posedge dst_clk) begin
    req_s1_ff <= dst_rst ? 1'h0 : req_ff;
    req_s2_ff <= dst_rst ? 1'h0 : req_s1_ff;
    req_s3_ff <= dst_rst ? 1'h0 : req_s2_ff;
    ack_ff <= dst_rst ? 1'h0 : (dst_new ? req_s2_ff : ack_ff);
    dst_data <= dst_rst ? RESET_VAL : (dst_new ? hold_ff : dst_data);
  end

endmodule

// ---- hw/pmic_fault_protection_control.sv ----
`timescale 1ns/10ps
// Behaviour
// - Buck above 125% sets its overvoltage flag and drops power-good.
// - Buck overvoltage flag needs the comparator held past the deglitch time.
// - A flagged buck has its switching drivers off until the flag clears.
// - Power-good returns only after all buck overvoltage flags clear.
// - Die above 150C turns every rail off.
// - Cooling below 125C restarts rails through the normal power-up.
// - Linear regulator reference ramps up gradually during power-up.
// - Linear regulator discharge closes on input lockout or latched undervoltage.
// - Linear regulator below 60% shuts down and latches undervoltage.
// - Undervoltage latch releases only on a fresh power-on reset.
// - Sense input discharge closes whenever external rail one enable is low.
// - Input overvoltage comparator is deglitched against noise pulses.
// - Qualified input overvoltage turns rails and inrush gate drive off.
// - Input above the selected power-on threshold starts power-up.
// - Serial target answers address 0x1b; host uses that address.
// - Serial target works at 100kbps and 400kbps; host keeps mode rate.
// - Reads and writes carry one or more consecutive data bytes.
// - Deglitched buck below 62.5% latches fault, rails off, power-good low.
`include "pmic_protect_map.svh"
module pmic_fault_protection_control
  import pmic_protect_pkg::*;
(
  input wire logic CLK,
  input wire logic RST,
  input wire logic LINK_CLK,
  input wire logic [2:0] BUCK_OV_CMP,
  input wire logic [2:0] BUCK_UV_CMP,
  input wire logic LDO_UV_CMP,
  input wire logic OT_HOT_CMP,
  input wire logic OT_COOL_CMP,
  input wire logic VIN_OV_CMP,
  input wire logic VIN_UVLO,
  input wire logic VIN_POR_OK,
  input wire logic THRESH_SEL,
  input wire logic I2C_SCL_IN,
  input wire logic I2C_SDA_IN,
  output logic I2C_SDA_OUT,
  output logic I2C_SDA_OE,
  output logic [2:0] BUCK_EN,
  output logic [2:0] BUCK_DRV_EN,
  output logic [2:0] BUCK_OV_FLAG,
  output logic LDO_EN,
  output logic [`SS_W-1:0] LDO_SS_REF,
  output logic LDO_DISCHARGE,
  output logic EXTERNAL_RAIL_ENABLE_ONE,
  output logic SENSE_DISCHARGE,
  output logic GATE_DRIVE_EN,
  output logic POWER_GOOD_OUT,
  output logic POR_THRESH_HIGH
);

  // Deglitch length per comparator index
  function automatic int unsigned dg_len(input int idx);
    if ((idx >= `CMP_BUCK_OV_LO && idx <= `CMP_BUCK_UV_HI) || idx == `CMP_LDO_UV ||
        idx == `CMP_VIN_OV) begin
      return `DEGLITCH_CYC;
    end
    return `SYNC_ONLY_CYC;
  endfunction

  // Register read decode
  function automatic logic [`BYTE_W-1:0] rd_byte(input logic [`BYTE_W-1:0] ptr,
      input logic [`BYTE_W-1:0] ctrl, input logic [`BYTE_W-1:0] stat);
    if (ptr == `REG_CTRL) begin
      return ctrl;
    end
    if (ptr == `REG_STAT) begin
      return stat;
    end
    return `REG_NONE;
  endfunction

  cmp_t raw_cmp;
  cmp_t cmp_q;
  logic [`CMP_N-1:0] q_vec;
  seq_state_t state_ff;
  seq_state_t nxt_state;
  logic uv_latch_ff;
  logic [`SS_W-1:0] ss_ff;
  logic [`STEP_W-1:0] step_ff;
  rail_out_t out_ff;
  rail_out_t nxt_out;
  localparam rail_out_t out_rst_val = '{sense_dis: 1'h1, default: '0};
  logic [`BYTE_W-1:0] ctrl_clk;
  logic [`BYTE_W-1:0] stat_clk;
  logic [`BYTE_W-1:0] stat_link;
  logic lrst_s1_ff;
  logic lrst;
  logic scl_s1_ff;
  logic scl_s2_ff;
  logic scl_s3_ff;
  logic sda_s1_ff;
  logic sda_s2_ff;
  logic sda_s3_ff;
  i2c_regs_t i2c_ff;
  i2c_regs_t nxt_i2c;

  // Pack comparator pins; all synchronised, only buck, regulator undervoltage and input overvoltage filtered
  assign raw_cmp = '{thresh_5v: THRESH_SEL, por_ok: VIN_POR_OK, uvlo: VIN_UVLO,
                     vin_ov: VIN_OV_CMP, ot_cool: OT_COOL_CMP, ot_hot: OT_HOT_CMP,
                     ldo_uv: LDO_UV_CMP, buck_uv: BUCK_UV_CMP, buck_ov: BUCK_OV_CMP};
  assign cmp_q = cmp_t'(q_vec);

  for (genvar g = 0; g < `CMP_N; g++) begin : g_dg
    deglitch_filter #(.LEN(dg_len(g))) u_dg (
      .clk(CLK),
      .rst(RST),
      .raw(raw_cmp[g]),
      .q(q_vec[g])
    );
  end

  // Fault decode
  wire logic uv_event = ((|cmp_q.buck_uv) | cmp_q.ldo_uv) && (state_ff == S_ON);
  wire logic nxt_uv_latch = uv_latch_ff | uv_event;
  wire logic ramp_done = (ss_ff == `SS_MAX);
  wire logic step_wrap = (step_ff == `STEP_W'(`RAMP_STEP_CYC - 1));
  wire logic rails_next = (nxt_state == S_RAMP) || (nxt_state == S_ON);

  // Sequencer next state, faults by priority
  always_comb begin
    nxt_state = state_ff;
    if (nxt_uv_latch) begin
      nxt_state = S_LATCH;
    end else if (cmp_q.vin_ov) begin
      nxt_state = S_VOV;
    end else if (cmp_q.ot_hot) begin
      nxt_state = S_OT;
    end else if (cmp_q.uvlo && state_ff != S_OT) begin
      nxt_state = S_OFF;
    end else begin
      unique case (state_ff)
        S_OFF: nxt_state = cmp_q.por_ok ? S_RAMP : S_OFF;
        S_RAMP: nxt_state = ramp_done ? S_ON : S_RAMP;
        S_ON: nxt_state = S_ON;
        S_OT: nxt_state = cmp_q.ot_cool ? S_OFF : S_OT;
        S_VOV: nxt_state = S_OFF;
        S_LATCH: nxt_state = S_LATCH;
        default: nxt_state = S_OFF;
      endcase
    end
  end

  // Soft-start ramp of the linear regulator reference
  wire logic [`SS_W-1:0] nxt_ss = (state_ff == S_RAMP) ?
      ((step_wrap && !ramp_done) ? ss_ff + `SS_W'(1) : ss_ff) :
      ((state_ff == S_ON) ? ss_ff : `SS_ZERO);
  wire logic [`STEP_W-1:0] nxt_step = (state_ff == S_RAMP && !step_wrap) ?
      step_ff + `STEP_W'(1) : '0;

  // Output decode
  always_comb begin
    nxt_out = '0;
    nxt_out.buck_en = {3{rails_next}};
    nxt_out.drv_en = {3{rails_next}} & ~cmp_q.buck_ov;
    nxt_out.ov_flag = cmp_q.buck_ov;
    nxt_out.ldo_en = rails_next;
    nxt_out.ldo_dis = cmp_q.uvlo | nxt_uv_latch;
    nxt_out.ext1 = rails_next & ctrl_clk[`CTRL_EXT1_BIT];
    nxt_out.sense_dis = ~nxt_out.ext1;
    nxt_out.gate = ~cmp_q.vin_ov && (nxt_state != S_VOV);
    nxt_out.power_good_out = (nxt_state == S_ON) && !(|cmp_q.buck_ov) && !nxt_uv_latch;
    nxt_out.thresh_5v = cmp_q.thresh_5v;
  end

  always_ff @(posedge CLK) begin
    state_ff <= RST ? S_OFF : nxt_state;
    uv_latch_ff <= RST ? 1'h0 : nxt_uv_latch;
    ss_ff <= RST ? `SS_ZERO : nxt_ss;
    step_ff <= RST ? '0 : nxt_step;
    out_ff <= RST ? out_rst_val : nxt_out;
  end

  assign BUCK_EN = out_ff.buck_en;
  assign BUCK_DRV_EN = out_ff.drv_en;
  assign BUCK_OV_FLAG = out_ff.ov_flag;
  assign LDO_EN = out_ff.ldo_en;
  assign LDO_SS_REF = ss_ff;
  assign LDO_DISCHARGE = out_ff.ldo_dis;
  assign EXTERNAL_RAIL_ENABLE_ONE = out_ff.ext1;
  assign SENSE_DISCHARGE = out_ff.sense_dis;
  assign GATE_DRIVE_EN = out_ff.gate;
  assign POWER_GOOD_OUT = out_ff.power_good_out;
  assign POR_THRESH_HIGH = out_ff.thresh_5v;

  // Status word toward the serial side
  assign stat_clk = {(state_ff == S_RAMP) || (state_ff == S_ON), out_ff.power_good_out,
                     cmp_q.vin_ov, cmp_q.ot_hot, uv_latch_ff, out_ff.ov_flag};

  cdc_word_handshake #(.RESET_VAL(`STAT_RESET)) u_stat_cdc (
    .src_clk(CLK),
    .src_rst(RST),
    .src_data(stat_clk),
    .dst_clk(LINK_CLK),
    .dst_rst(lrst),
    .dst_data(stat_link)
  );

  cdc_word_handshake #(.RESET_VAL(`CTRL_RESET)) u_ctrl_cdc (
    .src_clk(LINK_CLK),
    .src_rst(lrst),
    .src_data(i2c_ff.ctrl),
    .dst_clk(CLK),
    .dst_rst(RST),
    .dst_data(ctrl_clk)
  );

  // Link domain reset and bus line synchronisers
  always_ff @(posedge LINK_CLK) begin
    lrst_s1_ff <= RST;
    lrst <= lrst_s1_ff;
    scl_s1_ff <= I2C_SCL_IN;
    scl_s2_ff <= scl_s1_ff;
    scl_s3_ff <= scl_s2_ff;
    sda_s1_ff <= I2C_SDA_IN;
    sda_s2_ff <= sda_s1_ff;
    sda_s3_ff <= sda_s2_ff;
  end

  // Bus events from oversampled lines, fast enough for 400kbps
  wire logic scl_rise = scl_s2_ff && !scl_s3_ff;
  wire logic scl_fall = !scl_s2_ff && scl_s3_ff;
  wire logic bus_start = scl_s2_ff && scl_s3_ff && sda_s3_ff && !sda_s2_ff;
  wire logic bus_stop = scl_s2_ff && scl_s3_ff && !sda_s3_ff && sda_s2_ff;
  wire logic byte_done = (i2c_ff.bitcnt == `BITS_PER_BYTE);
  wire logic addr_hit = (i2c_ff.shreg[`BYTE_W-1:1] == `I2C_ADDR);
  wire logic [`BYTE_W-1:0] rd_now = rd_byte(i2c_ff.ptr, i2c_ff.ctrl, stat_link);

  // Serial target next state
  always_comb begin
    nxt_i2c = i2c_ff;
    if (scl_rise) begin
      unique case (i2c_ff.state)
        T_ADDR, T_REG, T_WDATA: begin
          nxt_i2c.shreg = {i2c_ff.shreg[`BYTE_W-2:0], sda_s2_ff};
          nxt_i2c.bitcnt = i2c_ff.bitcnt + `BITCNT_W'(1);
        end
        T_RDATA: nxt_i2c.bitcnt = i2c_ff.bitcnt + `BITCNT_W'(1);
        T_RACK: nxt_i2c.mack = ~sda_s2_ff;
        default: nxt_i2c.mack = i2c_ff.mack;
      endcase
    end
    if (scl_fall) begin
      unique case (i2c_ff.state)
        T_ADDR: if (byte_done) begin
          nxt_i2c.state = addr_hit ? T_ACK_A : T_IDLE;
          nxt_i2c.oe = addr_hit;
          nxt_i2c.rw = i2c_ff.shreg[0];
        end
        T_ACK_A: begin
          nxt_i2c.bitcnt = '0;
          nxt_i2c.state = i2c_ff.rw ? T_RDATA : T_REG;
          nxt_i2c.txsh = rd_now;
          nxt_i2c.oe = i2c_ff.rw && !rd_now[`BYTE_W-1];
        end
        T_REG: if (byte_done) begin
          nxt_i2c.ptr = i2c_ff.shreg;
          nxt_i2c.state = T_ACK_R;
          nxt_i2c.oe = 1'h1;
        end
        T_ACK_R, T_ACK_W: begin
          nxt_i2c.bitcnt = '0;
          nxt_i2c.state = T_WDATA;
          nxt_i2c.oe = 1'h0;
        end
        T_WDATA: if (byte_done) begin
          if (i2c_ff.ptr == `REG_CTRL) begin
            nxt_i2c.ctrl = i2c_ff.shreg;
          end
          nxt_i2c.ptr = i2c_ff.ptr + `BYTE_W'(1);
          nxt_i2c.state = T_ACK_W;
          nxt_i2c.oe = 1'h1;
        end
        T_RDATA: if (byte_done) begin
          nxt_i2c.oe = 1'h0;
          nxt_i2c.mack = 1'h0;
          nxt_i2c.state = T_RACK;
          nxt_i2c.ptr = i2c_ff.ptr + `BYTE_W'(1);
        end else if (i2c_ff.bitcnt != '0) begin
          nxt_i2c.txsh = {i2c_ff.txsh[`BYTE_W-2:0], 1'h0};
          nxt_i2c.oe = !i2c_ff.txsh[`BYTE_W-2];
        end
        T_RACK: begin
          nxt_i2c.bitcnt = '0;
          nxt_i2c.state = i2c_ff.mack ? T_RDATA : T_IDLE;
          nxt_i2c.txsh = rd_now;
          nxt_i2c.oe = i2c_ff.mack && !rd_now[`BYTE_W-1];
        end
        default: nxt_i2c.state = i2c_ff.state;
      endcase
    end
    if (bus_start) begin
      nxt_i2c.state = T_ADDR;
      nxt_i2c.bitcnt = '0;
      nxt_i2c.oe = 1'h0;
    end else if (bus_stop) begin
      nxt_i2c.state = T_IDLE;
      nxt_i2c.oe = 1'h0;
    end
  end

  always_ff @(posedge LINK_CLK) begin
    if (lrst) begin
      i2c_ff <= '{state: T_IDLE, ctrl: `CTRL_RESET, default: '0};
    end else begin
      i2c_ff <= nxt_i2c;
    end
  end

  // Open-drain data line: drive low only while enabled
  assign I2C_SDA_OUT = 1'h0;
  assign I2C_SDA_OE = i2c_ff.oe;

  // Checks
  sequence s_cool_exit;
    state_ff == S_OT ##1 state_ff == S_OFF;
  endsequence
  sequence s_ramp_entry;
    state_ff == S_OFF ##1 state_ff == S_RAMP;
  endsequence

  a_ov_drivers_off: assert property (@(posedge CLK) disable iff (RST)
    |cmp_q.buck_ov |=> (BUCK_DRV_EN & $past(cmp_q.buck_ov)) == 3'h0)
    else $error("flagged buck still switching");
  a_ov_power_good_out_low: assert property (@(posedge CLK) disable iff (RST)
    |cmp_q.buck_ov |=> !POWER_GOOD_OUT && BUCK_OV_FLAG == $past(cmp_q.buck_ov))
    else $error("overvoltage did not drop power-good");
  a_power_good_out_all_clear: assert property (@(posedge CLK) disable iff (RST)
    $rose(POWER_GOOD_OUT) |-> BUCK_OV_FLAG == 3'h0 && !uv_latch_ff)
    else $error("power-good rose with a flag active");
  a_ot_rails_off: assert property (@(posedge CLK) disable iff (RST)
    cmp_q.ot_hot |=> BUCK_EN == 3'h0 && !LDO_EN && !POWER_GOOD_OUT)
    else $error("rails on while over temperature");
  a_ot_restart: assert property (@(posedge CLK) disable iff (RST)
    (state_ff == S_OT && cmp_q.ot_cool && !cmp_q.ot_hot && !cmp_q.vin_ov && !uv_event)
    |-> s_cool_exit) else $error("no restart after cooling");
  a_ramp_from_zero: assert property (@(posedge CLK) disable iff (RST)
    s_ramp_entry |-> LDO_SS_REF == `SS_ZERO && !POWER_GOOD_OUT)
    else $error("soft-start did not begin at zero");
  a_ramp_one_step: assert property (@(posedge CLK) disable iff (RST)
    (state_ff == S_RAMP && $past(state_ff) == S_RAMP) |->
    (LDO_SS_REF == $past(LDO_SS_REF) || LDO_SS_REF == $past(LDO_SS_REF) + `SS_W'(1)))
    else $error("soft-start jumped");
  a_ldo_discharge: assert property (@(posedge CLK) disable iff (RST)
    (cmp_q.uvlo || uv_latch_ff) |=> LDO_DISCHARGE) else $error("discharge open");
  a_uv_shutdown: assert property (@(posedge CLK) disable iff (RST)
    uv_event |=> uv_latch_ff && BUCK_EN == 3'h0 && !LDO_EN && !POWER_GOOD_OUT)
    else $error("undervoltage did not latch shutdown");
  a_uv_sticky: assert property (@(posedge CLK) disable iff (RST)
    uv_latch_ff |=> uv_latch_ff && state_ff == S_LATCH) else $error("latch released");
  a_sense_discharge: assert property (@(posedge CLK) disable iff (RST)
    SENSE_DISCHARGE == !EXTERNAL_RAIL_ENABLE_ONE) else $error("sense discharge wrong");
  a_vin_ov_off: assert property (@(posedge CLK) disable iff (RST)
    cmp_q.vin_ov |=> !GATE_DRIVE_EN && BUCK_EN == 3'h0 && !LDO_EN)
    else $error("input overvoltage left drive on");
  a_por_start: assert property (@(posedge CLK) disable iff (RST)
    (state_ff == S_OFF && cmp_q.por_ok && !cmp_q.uvlo && !cmp_q.ot_hot &&
     !cmp_q.vin_ov && !uv_latch_ff) |=> state_ff == S_RAMP && LDO_EN)
    else $error("power-up did not start");
  a_addr_nack: assert property (@(posedge LINK_CLK) disable iff (lrst)
    (i2c_ff.state == T_ADDR && byte_done && scl_fall && !bus_start && !addr_hit)
    |=> i2c_ff.state == T_IDLE && !I2C_SDA_OE) else $error("foreign address acked");

endmodule

// ---- testbench/i2c_host_model.sv ----
`timescale 1ns/10ps
module i2c_host_model (
  input wire logic link_clk,
  input wire logic sda_line,
  output logic scl,
  output logic sda_low
);
  // Quarter bit of 400 kbps at the link clock
  localparam int Q = 42;
  // Bus idle, both lines released
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // Wait link clock edges
  task automatic tk(input int n);
    repeat (n) @(posedge link_clk);
  endtask
  // Start or repeated start
  task automatic start_c();
    sda_low <= 1'b0;
    tk(Q);
    scl <= 1'b1;
    tk(2 * Q);
    sda_low <= 1'b1;
    tk(2 * Q);
    scl <= 1'b0;
    tk(Q);
  endtask
  // Stop and release
  task automatic stop_c();
    sda_low <= 1'b1;
    tk(Q);
    scl <= 1'b1;
    tk(2 * Q);
    sda_low <= 1'b0;
    tk(2 * Q);
  endtask
  // One bit, line sampled mid high
  task automatic bit_x(input logic b, output logic r);
    sda_low <= !b;
    tk(Q);
    scl <= 1'b1;
    tk(Q);
    r = sda_line;
    tk(Q);
    scl <= 1'b0;
    tk(Q);
  endtask
  // Byte MSB first, then acknowledge slot
  task automatic byte_x(input logic [7:0] d, input logic a_out, output logic [7:0] r,
                        output logic a_in);
    logic b;
    for (int i = 7; i >= 0; i--) begin
      bit_x(d[i], b);
      r[i] = b;
    end
    bit_x(a_out, b);
    a_in = !b;
  endtask
  // Single byte register write
  task automatic wr(input logic [6:0] a, input logic [7:0] ra, input logic [7:0] d,
                    output logic ack);
    logic [7:0] r;
    logic k0, k1, k2;
    start_c();
    byte_x({a, 1'b0}, 1'b1, r, k0);
    byte_x(ra, 1'b1, r, k1);
    byte_x(d, 1'b1, r, k2);
    stop_c();
    ack = k0 & k1 & k2;
  endtask
  // Pointer set, repeated start, two byte read
  task automatic rd2(input logic [7:0] ra, output logic [7:0] b0, output logic [7:0] b1);
    logic [7:0] r;
    logic k;
    start_c();
    byte_x({7'h1b, 1'b0}, 1'b1, r, k);
    byte_x(ra, 1'b1, r, k);
    start_c();
    byte_x({7'h1b, 1'b1}, 1'b1, r, k);
    byte_x(8'hff, 1'b0, b0, k);
    byte_x(8'hff, 1'b1, b1, k);
    stop_c();
  endtask
endmodule

// ---- testbench/tb.sv ----
`timescale 1ns/10ps
module tb;
  import pmic_protect_pkg::*;
  logic CLK, RST, LINK_CLK, LDO_UV_CMP, OT_HOT_CMP, OT_COOL_CMP, VIN_OV_CMP, VIN_UVLO;
  logic VIN_POR_OK, THRESH_SEL, I2C_SDA_OUT, I2C_SDA_OE, LDO_EN, LDO_DISCHARGE;
  logic EXT1, SENSE_DISCHARGE, GATE_DRIVE_EN, POWER_GOOD_OUT, POR_THRESH_HIGH;
  logic scl, host_low, sda_w, ack;
  logic [2:0] BUCK_OV_CMP, BUCK_UV_CMP, BUCK_EN, BUCK_DRV_EN, BUCK_OV_FLAG;
  logic [7:0] LDO_SS_REF, b0, b1;
  int fails = 0;
  int checks_done = 0;
  // Open drain data line with pull-up
  assign sda_w = !(host_low | (I2C_SDA_OE & !I2C_SDA_OUT));
  pmic_fault_protection_control u_pmic_fault_protection_control (.CLK(CLK), .RST(RST),
    .LINK_CLK(LINK_CLK), .BUCK_OV_CMP(BUCK_OV_CMP), .BUCK_UV_CMP(BUCK_UV_CMP),
    .LDO_UV_CMP(LDO_UV_CMP), .OT_HOT_CMP(OT_HOT_CMP), .OT_COOL_CMP(OT_COOL_CMP),
    .VIN_OV_CMP(VIN_OV_CMP), .VIN_UVLO(VIN_UVLO), .VIN_POR_OK(VIN_POR_OK),
    .THRESH_SEL(THRESH_SEL), .I2C_SCL_IN(scl), .I2C_SDA_IN(sda_w),
    .I2C_SDA_OUT(I2C_SDA_OUT), .I2C_SDA_OE(I2C_SDA_OE), .BUCK_EN(BUCK_EN),
    .BUCK_DRV_EN(BUCK_DRV_EN), .BUCK_OV_FLAG(BUCK_OV_FLAG), .LDO_EN(LDO_EN),
    .LDO_SS_REF(LDO_SS_REF), .LDO_DISCHARGE(LDO_DISCHARGE), .EXTERNAL_RAIL_ENABLE_ONE(EXT1),
    .SENSE_DISCHARGE(SENSE_DISCHARGE), .GATE_DRIVE_EN(GATE_DRIVE_EN),
    .POWER_GOOD_OUT(POWER_GOOD_OUT), .POR_THRESH_HIGH(POR_THRESH_HIGH));
  i2c_host_model u_i2c_host_model (.link_clk(LINK_CLK), .sda_line(sda_w), .scl(scl),
    .sda_low(host_low));
  // Clocks of unrelated phase
  initial begin
    CLK = 1'b0;
    forever #12.5 CLK = ~CLK;
  end
  initial begin
    LINK_CLK = 1'b0;
    #4;
    forever #7.5 LINK_CLK = ~LINK_CLK;
  end
  // Verdict and stop
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Compare one value
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Clock edge waits
  task automatic cyc(input int n);
    repeat (n) @(posedge CLK);
  endtask
  task automatic wait_en(input logic [2:0] v, input int lim);
    for (int n = 0; n < lim && BUCK_EN !== v; n++) @(posedge CLK);
    @(negedge CLK);
  endtask
  task automatic ramp_done();
    for (int n = 0; n < 10600 && POWER_GOOD_OUT !== 1'b1; n++) @(posedge CLK);
    @(negedge CLK);
    chk("ref top", LDO_SS_REF, 8'hff);
    chk("power_good_out on", POWER_GOOD_OUT, 8'h01);
  endtask
  task automatic do_reset();
    @(posedge CLK);
    RST <= 1'b1;
    cyc(3);
    RST <= 1'b0;
  endtask
  // Power-up from the threshold, soft-start ramp
  task automatic t_power_up();
    @(posedge CLK);
    VIN_POR_OK <= 1'b1;
    THRESH_SEL <= 1'b1;
    wait_en(3'h7, 30);
    chk("rails up", BUCK_EN, 8'h07);
    chk("strap hi", POR_THRESH_HIGH, 8'h01);
    chk("power_good_out ramp", POWER_GOOD_OUT, 8'h00);
    cyc(200);
    @(negedge CLK);
    chk("ref mid", (LDO_SS_REF > 8'h02) && (LDO_SS_REF < 8'h08), 8'h01);
    ramp_done();
    chk("sense off", SENSE_DISCHARGE, 8'h00);
  endtask
  // Buck overvoltage glitch, flag, driver off, power-good
  task automatic t_buck_ov();
    @(posedge CLK);
    BUCK_OV_CMP <= 3'b010;
    cyc(40);
    BUCK_OV_CMP <= 3'b000;
    cyc(120);
    @(negedge CLK);
    chk("ov glitch", BUCK_OV_FLAG, 8'h00);
    chk("pg glitch", POWER_GOOD_OUT, 8'h01);
    @(posedge CLK);
    BUCK_OV_CMP <= 3'b010;
    cyc(90);
    @(negedge CLK);
    chk("ov flag", BUCK_OV_FLAG, 8'h02);
    chk("pg ov", POWER_GOOD_OUT, 8'h00);
    chk("rails kept", BUCK_EN, 8'h07);
    chk("drv off", BUCK_DRV_EN, 8'h05);
    @(posedge CLK);
    BUCK_OV_CMP <= 3'b001;
    cyc(90);
    @(negedge CLK);
    chk("ov swap", BUCK_OV_FLAG, 8'h01);
    chk("drv swap", BUCK_DRV_EN, 8'h06);
    chk("pg one left", POWER_GOOD_OUT, 8'h00);
    @(posedge CLK);
    BUCK_OV_CMP <= 3'b000;
    cyc(12);
    @(negedge CLK);
    chk("drv back", BUCK_DRV_EN, 8'h07);
    chk("pg back", POWER_GOOD_OUT, 8'h01);
  endtask
  // Serial target: address, control write, two byte read
  task automatic t_serial();
    u_i2c_host_model.wr(7'h1c, 8'h00, 8'h00, ack);
    chk("foreign ack", ack, 8'h00);
    u_i2c_host_model.wr(7'h1b, 8'h00, 8'h00, ack);
    chk("own ack", ack, 8'h01);
    cyc(30);
    @(negedge CLK);
    chk("ext off", EXT1, 8'h00);
    chk("sense on", SENSE_DISCHARGE, 8'h01);
    u_i2c_host_model.rd2(8'h00, b0, b1);
    chk("ctrl read", b0, 8'h00);
    chk("status read", b1, 8'hc0);
    u_i2c_host_model.wr(7'h1b, 8'h00, 8'h01, ack);
    cyc(30);
    @(negedge CLK);
    chk("ext on", EXT1, 8'h01);
    chk("sense back", SENSE_DISCHARGE, 8'h00);
  endtask
  // Over-temperature shutdown and restart
  task automatic t_over_temp();
    @(posedge CLK);
    OT_HOT_CMP <= 1'b1;
    cyc(8);
    @(negedge CLK);
    chk("ot rails", BUCK_EN, 8'h00);
    chk("ot ldo", LDO_EN, 8'h00);
    @(posedge CLK);
    OT_HOT_CMP <= 1'b0;
    OT_COOL_CMP <= 1'b1;
    wait_en(3'h7, 30);
    chk("ot restart", BUCK_EN, 8'h07);
    chk("ot ref low", LDO_SS_REF < 8'h02, 8'h01);
    @(posedge CLK);
    OT_COOL_CMP <= 1'b0;
    ramp_done();
  endtask
  // Input overvoltage glitch and qualified trip
  task automatic t_vin_ov();
    @(posedge CLK);
    VIN_OV_CMP <= 1'b1;
    cyc(40);
    VIN_OV_CMP <= 1'b0;
    cyc(10);
    @(negedge CLK);
    chk("vov glitch", GATE_DRIVE_EN, 8'h01);
    @(posedge CLK);
    VIN_OV_CMP <= 1'b1;
    cyc(90);
    @(negedge CLK);
    chk("vov gate", GATE_DRIVE_EN, 8'h00);
    chk("vov rails", {LDO_EN, BUCK_EN}, 8'h00);
    @(posedge CLK);
    VIN_OV_CMP <= 1'b0;
    wait_en(3'h7, 30);
    chk("vov gate back", GATE_DRIVE_EN, 8'h01);
    ramp_done();
  endtask
  // Regulator undervoltage latch, lockout discharge
  task automatic t_ldo_uv();
    @(posedge CLK);
    LDO_UV_CMP <= 1'b1;
    cyc(90);
    LDO_UV_CMP <= 1'b0;
    cyc(300);
    @(negedge CLK);
    chk("uv rails", {LDO_EN, BUCK_EN}, 8'h00);
    chk("uv dis", LDO_DISCHARGE, 8'h01);
    @(posedge CLK);
    VIN_UVLO <= 1'b1;
    THRESH_SEL <= 1'b0;
    do_reset();
    cyc(10);
    @(negedge CLK);
    chk("uvlo dis", LDO_DISCHARGE, 8'h01);
    chk("strap lo", POR_THRESH_HIGH, 8'h00);
    @(posedge CLK);
    VIN_UVLO <= 1'b0;
    wait_en(3'h7, 30);
    chk("latch gone", LDO_DISCHARGE, 8'h00);
    ramp_done();
  endtask
  // Buck undervoltage latch
  task automatic t_buck_uv();
    @(posedge CLK);
    BUCK_UV_CMP <= 3'b100;
    cyc(90);
    BUCK_UV_CMP <= 3'b000;
    cyc(100);
    @(negedge CLK);
    chk("buv rails", {LDO_EN, BUCK_EN}, 8'h00);
    chk("buv pg", POWER_GOOD_OUT, 8'h00);
  endtask
  // Main sequence
  initial begin
    {BUCK_OV_CMP, BUCK_UV_CMP, LDO_UV_CMP, OT_HOT_CMP, OT_COOL_CMP} = '0;
    {VIN_OV_CMP, VIN_UVLO, VIN_POR_OK, THRESH_SEL} = '0;
    RST = 1'b1;
    cyc(3);
    RST <= 1'b0;
    cyc(5);
    t_power_up();
    t_buck_ov();
    t_serial();
    t_over_temp();
    t_vin_ov();
    t_ldo_uv();
    t_buck_uv();
    end_sim();
  end
  // Hang guard
  initial begin
    #2000000;
    fails++;
    end_sim();
  end
endmodule
